//--- core/seg_pkg.sv
// package: register map, codes, carriers and timing of the segmented replay sequencer
// Operation
// - equal segments, one segment per trigger
// - segment length counts samples per channel
// - hardware re-arms after fixed short interval
// - external and software triggers both start segments
// - mode code 200h selects buffered replay
// - mode code 1000h selects streaming replay
// - buffered repeat 0 loops memory forever
// - buffered repeat 1 plays memory once
// - streaming repeat counts segments, 0 endless
// - streaming ignores the total sample count
// - two bytes per sample, memory sized
// - one, two or four channels scale limits
// - idle outputs show the stop level
package seg_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_SEGLEN_L = 8'h04;
    localparam logic [7:0] OFS_SEGLEN_H = 8'h08;
    localparam logic [7:0] OFS_TOTAL_L  = 8'h0C;
    localparam logic [7:0] OFS_TOTAL_H  = 8'h10;
    localparam logic [7:0] OFS_REPEAT_L = 8'h14;
    localparam logic [7:0] OFS_REPEAT_H = 8'h18;
    localparam logic [7:0] OFS_CTRL     = 8'h1C;
    localparam logic [7:0] OFS_CHAN     = 8'h20;
    localparam logic [7:0] OFS_STOP     = 8'h24;
    localparam logic [7:0] OFS_STATUS   = 8'h28;
    localparam logic [7:0] OFS_SEGCNT   = 8'h2C;
    localparam logic [7:0] OFS_MEMADDR  = 8'h30;
    localparam logic [7:0] OFS_MEMDATA  = 8'h34;
    localparam logic [7:0] OFS_STREAM   = 8'h38;

    // control register bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CTRL_SWTRG = 2;

    // status register field positions
    localparam int STAT_STATE = 0;
    localparam int STAT_FIFO  = 8;
    localparam int STAT_SEG   = 16;

    // operating mode codes
    localparam logic [31:0] MODE_BUFFERED  = 32'h0000_0200;
    localparam logic [31:0] MODE_STREAMING = 32'h0000_1000;

    // reset values
    localparam logic [31:0] RST_MODE   = 32'h0000_0000;
    localparam logic [63:0] RST_SEGLEN = 64'h0000_0000_0000_0010;
    localparam logic [63:0] RST_TOTAL  = 64'h0000_0000_0000_0020;
    localparam logic [63:0] RST_REPEAT = 64'h0000_0000_0000_0001;
    localparam logic [15:0] RST_STOP   = 16'h0000;

    // sample geometry
    localparam int SAMPLE_W  = 16;
    localparam int CHAN_IDXW = 2;

    // re-arm interval, clock at 4 ns
    localparam int CLK_PERIOD_PS = 4000;
    localparam int REARM_PS      = 20000;
    localparam int REARM_CYC     = (REARM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_PLAY  = 4'b0100,
        ST_REARM = 4'b1000
    } seq_state_e;

    // one output word of the replay stream
    typedef struct packed {
        logic [CHAN_IDXW-1:0] chan;
        logic [SAMPLE_W-1:0]  data;
    } sample_s;

endpackage

//--- core/seg_fifo.sv
// file: synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module seg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    // fill side
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    // drain side
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic [WIDTH-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_q;
    logic [AW:0]      rptr_q;
    logic             push;
    logic             pop;

    // full when pointers differ only in the wrap bit
    assign wr_ready = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
    assign rd_valid = (wptr_q != rptr_q);
    assign rd_data  = mem[rptr_q[AW-1:0]];
    assign push     = ce && wr_valid && wr_ready;
    assign pop      = ce && rd_valid && rd_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_q[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wptr_q <= '0;
        end else if (push) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rptr_q <= '0;
        end else if (pop) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

endmodule

//--- core/segmented_trigger_replay.sv
// file: segmented trigger replay sequencer with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module segmented_trigger_replay #(
    parameter int MEM_SAMPLES = 4096,
    parameter int FIFO_DEPTH  = 32
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // trigger pin
    input  wire logic              trig_in,
    // replay output
    output seg_pkg::sample_s       sample_out,
    output logic                   sample_valid,
    output logic                   replay_active
);
    localparam int MAW = $clog2(MEM_SAMPLES);

    // sample memory, one 16-bit sample per word
    logic [seg_pkg::SAMPLE_W-1:0] smem [MEM_SAMPLES];

    logic                      ph_q;
    logic                      ph_wr_q;
    logic [7:0]                ph_addr_q;
    logic                      rd_wait_q;
    logic [31:0]               hrdata_q;
    logic [31:0]               mode_q;
    logic [63:0]               seglen_q;
    logic [63:0]               total_q;
    logic [63:0]               repeat_q;
    logic [1:0]                chan_sel_q;
    logic [15:0]               stop_q;
    logic [MAW-1:0]            mem_addr_q;
    logic [2:0]                trig_s_q;
    logic                      trig_lvl_q;
    seg_pkg::seq_state_e       state_q;
    logic [63:0]               word_q;
    logic [63:0]               play_addr_q;
    logic [63:0]               seg_cnt_q;
    logic [7:0]                rearm_q;
    seg_pkg::sample_s          out_q;
    logic                      out_valid_q;
    logic                      wr_fire;
    logic                      stream_wr;
    logic                      fifo_wr_ready;
    logic                      fifo_rd_valid;
    logic                      fifo_pop;
    logic [15:0]               fifo_data;
    logic                      start_p;
    logic                      stop_p;
    logic                      swtrig_p;
    logic                      ext_evt;
    logic                      trig_evt;
    logic                      is_stream;
    logic                      mode_ok;
    logic                      advance;
    logic                      seg_last;
    logic                      mem_last;
    logic [63:0]               seg_words;
    logic [63:0]               mem_words;

    // samples per trigger scaled by enabled channel count
    function automatic logic [63:0] scale_words(input logic [63:0] n, input logic [1:0] sel);
        case (sel)
            2'd0:    scale_words = n;
            2'd1:    scale_words = {n[62:0], 1'b0};
            default: scale_words = {n[61:0], 2'b00};
        endcase
    endfunction

    // ---------------- bus slave ----------------
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign stream_wr = ph_q && ph_wr_q && (ph_addr_q == seg_pkg::OFS_STREAM);
    assign hreadyout = ce && !(ph_q && !ph_wr_q && !rd_wait_q) && !(stream_wr && !fifo_wr_ready);
    assign wr_fire   = ph_q && ph_wr_q && hreadyout;

    always_ff @(posedge clk) begin
        if (reset) begin
            ph_q      <= 1'b0;
            ph_wr_q   <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (ce && hready) begin
            ph_q      <= hsel && htrans[1];
            ph_wr_q   <= hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end

    // reads take one wait state so the registered read data is ready
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_wait_q <= 1'b0;
        end else if (ce) begin
            rd_wait_q <= ph_q && !ph_wr_q && !rd_wait_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ce && ph_q && !ph_wr_q && !rd_wait_q) begin
            case (ph_addr_q)
                seg_pkg::OFS_MODE:     hrdata_q <= mode_q;
                seg_pkg::OFS_SEGLEN_L: hrdata_q <= seglen_q[31:0];
                seg_pkg::OFS_SEGLEN_H: hrdata_q <= seglen_q[63:32];
                seg_pkg::OFS_TOTAL_L:  hrdata_q <= total_q[31:0];
                seg_pkg::OFS_TOTAL_H:  hrdata_q <= total_q[63:32];
                seg_pkg::OFS_REPEAT_L: hrdata_q <= repeat_q[31:0];
                seg_pkg::OFS_REPEAT_H: hrdata_q <= repeat_q[63:32];
                seg_pkg::OFS_CHAN:     hrdata_q <= {30'h0000_0000, chan_sel_q};
                seg_pkg::OFS_STOP:     hrdata_q <= {16'h0000, stop_q};
                seg_pkg::OFS_STATUS:   hrdata_q <= {seg_cnt_q[15:0], 7'h00, fifo_rd_valid,
                                                    4'h0, state_q};
                seg_pkg::OFS_SEGCNT:   hrdata_q <= seg_cnt_q[31:0];
                seg_pkg::OFS_MEMADDR:  hrdata_q <= 32'(mem_addr_q);
                default:               hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q     <= seg_pkg::RST_MODE;
            seglen_q   <= seg_pkg::RST_SEGLEN;
            total_q    <= seg_pkg::RST_TOTAL;
            repeat_q   <= seg_pkg::RST_REPEAT;
            chan_sel_q <= 2'd0;
            stop_q     <= seg_pkg::RST_STOP;
        end else if (ce && wr_fire) begin
            case (ph_addr_q)
                seg_pkg::OFS_MODE:     mode_q           <= hwdata;
                seg_pkg::OFS_SEGLEN_L: seglen_q[31:0]   <= hwdata;
                seg_pkg::OFS_SEGLEN_H: seglen_q[63:32]  <= hwdata;
                seg_pkg::OFS_TOTAL_L:  total_q[31:0]    <= hwdata;
                seg_pkg::OFS_TOTAL_H:  total_q[63:32]   <= hwdata;
                seg_pkg::OFS_REPEAT_L: repeat_q[31:0]   <= hwdata;
                seg_pkg::OFS_REPEAT_H: repeat_q[63:32]  <= hwdata;
                seg_pkg::OFS_CHAN:     chan_sel_q       <= hwdata[1:0];
                seg_pkg::OFS_STOP:     stop_q           <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    assign start_p  = wr_fire && (ph_addr_q == seg_pkg::OFS_CTRL) && hwdata[seg_pkg::CTRL_START];
    assign stop_p   = wr_fire && (ph_addr_q == seg_pkg::OFS_CTRL) && hwdata[seg_pkg::CTRL_STOP];
    assign swtrig_p = wr_fire && (ph_addr_q == seg_pkg::OFS_CTRL) && hwdata[seg_pkg::CTRL_SWTRG];

    // sample memory load with auto-incrementing address, two bytes per sample
    always_ff @(posedge clk) begin
        if (reset) begin
            mem_addr_q <= '0;
        end else if (ce && wr_fire && (ph_addr_q == seg_pkg::OFS_MEMADDR)) begin
            mem_addr_q <= hwdata[MAW-1:0];
        end else if (ce && wr_fire && (ph_addr_q == seg_pkg::OFS_MEMDATA)) begin
            mem_addr_q <= mem_addr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && wr_fire && (ph_addr_q == seg_pkg::OFS_MEMDATA)) begin
            smem[mem_addr_q] <= hwdata[15:0];
        end
    end

    // streaming blocks from the host pass through the FIFO
    seg_fifo #(
        .WIDTH (seg_pkg::SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .ce       (ce),
        .wr_valid (stream_wr),
        .wr_ready (fifo_wr_ready),
        .wr_data  (hwdata[15:0]),
        .rd_valid (fifo_rd_valid),
        .rd_ready (fifo_pop),
        .rd_data  (fifo_data)
    );

    // ---------------- trigger detection ----------------
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_s_q <= 3'b000;
        end else if (ce) begin
            trig_s_q <= {trig_s_q[1:0], trig_in};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_lvl_q <= 1'b0;
        end else if (ce && (trig_s_q[1] == trig_s_q[2])) begin
            trig_lvl_q <= trig_s_q[2];
        end
    end

    assign ext_evt  = (trig_s_q[1] == trig_s_q[2]) && trig_s_q[2] && !trig_lvl_q;
    assign trig_evt = ext_evt || swtrig_p;

    // ---------------- sequencer ----------------
    assign is_stream = (mode_q == seg_pkg::MODE_STREAMING);
    assign mode_ok   = is_stream || (mode_q == seg_pkg::MODE_BUFFERED);
    assign seg_words = scale_words(seglen_q, chan_sel_q);
    assign mem_words = scale_words(total_q, chan_sel_q);
    assign advance   = (state_q == seg_pkg::ST_PLAY) && !stop_p && (!is_stream || fifo_rd_valid);
    assign fifo_pop  = advance && is_stream;
    assign seg_last  = (word_q == seg_words - 64'h1);
    assign mem_last  = (play_addr_q == mem_words - 64'h1);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= seg_pkg::ST_IDLE;
        end else if (ce) begin
            case (state_q)
                seg_pkg::ST_IDLE: begin
                    if (start_p && mode_ok) begin
                        state_q <= seg_pkg::ST_ARMED;
                    end
                end
                seg_pkg::ST_ARMED: begin
                    if (stop_p) begin
                        state_q <= seg_pkg::ST_IDLE;
                    end else if (trig_evt && (!is_stream || fifo_rd_valid)) begin
                        state_q <= seg_pkg::ST_PLAY;
                    end
                end
                seg_pkg::ST_PLAY: begin
                    if (stop_p) begin
                        state_q <= seg_pkg::ST_IDLE;
                    end else if (advance && seg_last) begin
                        if (is_stream && (repeat_q != 64'h0) &&
                            (seg_cnt_q + 64'h1 == repeat_q)) begin
                            state_q <= seg_pkg::ST_IDLE;
                        end else if (!is_stream && mem_last && (repeat_q != 64'h0)) begin
                            state_q <= seg_pkg::ST_IDLE;
                        end else begin
                            state_q <= seg_pkg::ST_REARM;
                        end
                    end
                end
                seg_pkg::ST_REARM: begin
                    if (stop_p) begin
                        state_q <= seg_pkg::ST_IDLE;
                    end else if (rearm_q == 8'd0) begin
                        state_q <= seg_pkg::ST_ARMED;
                    end
                end
                default: state_q <= seg_pkg::ST_IDLE;
            endcase
        end
    end

    // fixed re-arm interval counter
    always_ff @(posedge clk) begin
        if (reset) begin
            rearm_q <= 8'd0;
        end else if (ce) begin
            if (state_q != seg_pkg::ST_REARM) begin
                rearm_q <= 8'(seg_pkg::REARM_CYC - 1);
            end else if (rearm_q != 8'd0) begin
                rearm_q <= rearm_q - 8'd1;
            end
        end
    end

    // word counter within a segment
    always_ff @(posedge clk) begin
        if (reset) begin
            word_q <= 64'h0;
        end else if (ce) begin
            if (state_q != seg_pkg::ST_PLAY) begin
                word_q <= 64'h0;
            end else if (advance) begin
                word_q <= seg_last ? 64'h0 : word_q + 64'h1;
            end
        end
    end

    // buffered read pointer wraps to the first segment
    always_ff @(posedge clk) begin
        if (reset) begin
            play_addr_q <= 64'h0;
        end else if (ce) begin
            if (state_q == seg_pkg::ST_IDLE) begin
                play_addr_q <= 64'h0;
            end else if (advance && !is_stream) begin
                play_addr_q <= mem_last ? 64'h0 : play_addr_q + 64'h1;
            end
        end
    end

    // completed segment count
    always_ff @(posedge clk) begin
        if (reset) begin
            seg_cnt_q <= 64'h0;
        end else if (ce) begin
            if (start_p && (state_q == seg_pkg::ST_IDLE)) begin
                seg_cnt_q <= 64'h0;
            end else if (advance && seg_last) begin
                seg_cnt_q <= seg_cnt_q + 64'h1;
            end
        end
    end

    // output register, stop level whenever no sample is played
    always_ff @(posedge clk) begin
        if (reset) begin
            out_q       <= '{chan: '0, data: seg_pkg::RST_STOP};
            out_valid_q <= 1'b0;
        end else if (ce) begin
            out_valid_q <= advance;
            if (advance) begin
                out_q.chan <= word_q[1:0] & ((2'b01 << chan_sel_q) - 2'b01);
                out_q.data <= is_stream ? fifo_data : smem[play_addr_q[MAW-1:0]];
            end else begin
                out_q.chan <= '0;
                out_q.data <= stop_q;
            end
        end
    end

    assign sample_out    = out_q;
    assign sample_valid  = out_valid_q;
    assign replay_active = (state_q != seg_pkg::ST_IDLE);

    // ---------------- assertions ----------------
    property p_trig_start;
        @(posedge clk) disable iff (reset || !ce)
        (state_q == seg_pkg::ST_ARMED) && trig_evt && !stop_p && !is_stream
            |=> (state_q == seg_pkg::ST_PLAY);
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start segment");

    property p_trig_ignored;
        @(posedge clk) disable iff (reset || !ce)
        (state_q == seg_pkg::ST_REARM) && (rearm_q != 8'd0) && trig_evt
            |=> (state_q != seg_pkg::ST_PLAY);
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken during re-arm");

    property p_rearm_len;
        @(posedge clk) disable iff (reset || !ce)
        $rose(state_q == seg_pkg::ST_REARM) |-> (state_q == seg_pkg::ST_REARM)[*5]
            ##1 (state_q != seg_pkg::ST_REARM);
    endproperty
    a_rearm_len: assert property (p_rearm_len) else $error("re-arm interval wrong");

    property p_stop_level;
        @(posedge clk) disable iff (reset)
        !out_valid_q && $past(ce) && !$past(reset) |-> (out_q.data == $past(stop_q));
    endproperty
    a_stop_level: assert property (p_stop_level) else $error("idle output not stop level");

    property p_seg_words;
        @(posedge clk) disable iff (reset || !ce)
        $rose(state_q == seg_pkg::ST_REARM) |-> $past(word_q) == seg_words - 64'h1;
    endproperty
    a_seg_words: assert property (p_seg_words) else $error("segment length wrong");

    property p_once_stop;
        @(posedge clk) disable iff (reset || !ce)
        advance && seg_last && !is_stream && mem_last && (repeat_q == 64'h1) && !start_p
            |=> (state_q == seg_pkg::ST_IDLE) ##1 !sample_valid;
    endproperty
    a_once_stop: assert property (p_once_stop) else $error("single pass did not stop");

    property p_endless_wrap;
        @(posedge clk) disable iff (reset || !ce)
        advance && !is_stream && mem_last && (repeat_q == 64'h0)
            |=> (play_addr_q == 64'h0) && (state_q != seg_pkg::ST_IDLE || $past(stop_p));
    endproperty
    a_endless_wrap: assert property (p_endless_wrap) else $error("endless replay ended");

    property p_stream_count;
        @(posedge clk) disable iff (reset || !ce)
        $fell(replay_active) && is_stream && !$past(stop_p) |-> (seg_cnt_q == repeat_q);
    endproperty
    a_stream_count: assert property (p_stream_count) else $error("segment count mismatch");

    property p_stream_stall;
        @(posedge clk) disable iff (reset || !ce)
        is_stream && !fifo_rd_valid |=> !sample_valid;
    endproperty
    a_stream_stall: assert property (p_stream_stall) else $error("output without host data");

    property p_mode_gate;
        @(posedge clk) disable iff (reset || !ce)
        start_p && (state_q == seg_pkg::ST_IDLE) && !mode_ok |=> (state_q == seg_pkg::ST_IDLE);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("start in unknown mode");

endmodule

//--- test/seg_trig_model.sv
// file: external trigger source model driving the trigger pin
`timescale 1ns/1ps
module seg_trig_model (
    // clock
    input  wire logic clk,
    // request from the bench
    input  wire logic fire,
    // trigger pin
    output logic      trig_in
);
    int n = 0;
    // rising edge held four cycles so the synchroniser sees it
    always @(posedge clk) begin
        if (fire) begin
            n <= 6;
        end else if (n > 0) begin
            n <= n - 1;
        end
    end
    assign trig_in = (n > 2);
endmodule

//--- test/segmented_trigger_replay_tb_top.sv
// file: self-checking bench of the segmented replay sequencer
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module segmented_trigger_replay_tb_top;
    logic             clk = 0, reset = 1, hsel = 0, hwrite = 0, fire = 0;
    logic             trig_in, hreadyout, hresp, sample_valid, replay_active, rdy_q;
    logic [1:0]       htrans = 0;
    logic [31:0]      haddr = 0, hwdata = 0, hrdata, rd_q, r;
    logic [15:0]      last_q;
    logic [1:0]       last_c_q;
    seg_pkg::sample_s sample_out;
    int               fail_count = 0, tests_run = 0, nvalid = 0;
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        rdy_q <= hreadyout;
        rd_q <= hrdata;
        if (sample_valid === 1'b1) begin
            nvalid <= nvalid + 1;
            last_q <= sample_out.data;
            last_c_q <= sample_out.chan;
        end
    end
    segmented_trigger_replay dut_u (.clk(clk), .reset(reset), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .trig_in(trig_in), .sample_out(sample_out), .sample_valid(sample_valid),
        .replay_active(replay_active));
    seg_trig_model trig_u (.clk(clk), .fire(fire), .trig_in(trig_in));
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin @(posedge clk); #1; end while (rdy_q !== 1'b1);
        htrans <= 2'h0;
        hsel <= 0;
        hwdata <= d;
        do begin @(posedge clk); #1; end while (rdy_q !== 1'b1);
        r = rd_q;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 0, 32'h0);
        `CHK(n, e, r)
        `CHK("hresp", 1'b0, hresp)
    endtask
    task automatic wait_st(input logic [3:0] e);
        repeat (300) begin
            xfer(seg_pkg::OFS_STATUS, 0, 32'h0);
            if (r[3:0] === e) break;
        end
        `CHK("state", e, r[3:0])
    endtask
    task automatic print_verdict;
        $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        rd_chk("mode", seg_pkg::OFS_MODE, 32'h0);
        rd_chk("seglen", seg_pkg::OFS_SEGLEN_L, 32'h10);
        rd_chk("unmapped", 8'h3C, 32'h0);
        $display("test reset done");
        xfer(seg_pkg::OFS_CHAN, 1, 32'h0);
        xfer(seg_pkg::OFS_TOTAL_L, 1, 32'h20);
        xfer(seg_pkg::OFS_STOP, 1, 32'h55);
        xfer(seg_pkg::OFS_MEMADDR, 1, 32'h0);
        for (int i = 0; i < 32; i++) xfer(seg_pkg::OFS_MEMDATA, 1, 32'h100 + i);
        xfer(seg_pkg::OFS_MODE, 1, seg_pkg::MODE_BUFFERED);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h1);
        wait_st(4'h2);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        wait_st(4'h2);
        `CHK("seg1 words", 16, nvalid)
        `CHK("seg1 last", 16'h10F, last_q)
        @(posedge clk) fire <= 1;
        @(posedge clk) fire <= 0;
        wait_st(4'h1);
        `CHK("seg2 words", 32, nvalid)
        `CHK("seg2 last", 16'h11F, last_q)
        `CHK("stop level", 16'h55, sample_out.data)
        $display("test buffered done");
        xfer(seg_pkg::OFS_MODE, 1, seg_pkg::MODE_STREAMING);
        xfer(seg_pkg::OFS_TOTAL_L, 1, 32'h0);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h1);
        wait_st(4'h2);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        repeat (20) @(posedge clk);
        `CHK("empty fifo", 32, nvalid)
        for (int i = 0; i < 16; i++) xfer(seg_pkg::OFS_STREAM, 1, 32'h200 + i);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        wait_st(4'h1);
        `CHK("stream words", 48, nvalid)
        `CHK("stream last", 16'h20F, last_q)
        `CHK("active off", 1'b0, replay_active)
        $display("test streaming done");
        xfer(seg_pkg::OFS_CHAN, 1, 32'h1);
        xfer(seg_pkg::OFS_TOTAL_L, 1, 32'h20);
        xfer(seg_pkg::OFS_REPEAT_L, 1, 32'h0);
        for (int i = 32; i < 64; i++) xfer(seg_pkg::OFS_MEMDATA, 1, 32'h100 + i);
        xfer(seg_pkg::OFS_MODE, 1, seg_pkg::MODE_BUFFERED);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h1);
        wait_st(4'h2);
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        wait_st(4'h2);
        `CHK("2ch seg words", 80, nvalid)
        `CHK("2ch last chan", 2'h1, last_c_q)
        xfer(seg_pkg::OFS_CTRL, 1, 32'h4);
        wait_st(4'h2);
        `CHK("wrap words", 112, nvalid)
        `CHK("wrap last", 16'h13F, last_q)
        xfer(seg_pkg::OFS_CTRL, 1, 32'h2);
        wait_st(4'h1);
        `CHK("endless stop", 1'b0, replay_active)
        $display("test endless done");
        print_verdict;
    end
endmodule
